// [logic/pdc_power_down_controller.sv]
// power-down controller: timers, clock-stop/slow requests, management irq
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - suspend period from upper timer nibble
// - wake period from lower nibble, 54us-55ms
// - suspend timer runs only while disable clear
// - suspend counts only after stand-by expiry
// - hardware mode: clock-stop at suspend expiry
// - software mode: management irq at expiry
// - irq drops clock-stop, wake timer re-asserts
// - mode bit 2 disables wake timer
// - mode bits 7/6 select hardware/software
// - mode bit 5 gates processor irq
// - mode bit 3: irq forces clock-slow off
// - control bit 7 raises management irq
// - control bit 6 alone clears management irq
// - control bit 5 forces clock-stop on
// - control bit 4 forces clock-stop off
// - control bit 3 forces clock-slow on
// - control bit 2 forces clock-slow off
// - suspend re-enable restarts, irq again
// - control bit 0 forces reset-mask inactive
// - indicator led flashes, bit 2 polarity
// - indicator bit 1 picks management style
// - special address match, memory or io
// - flag at suspend expiry, cleared by disable
// - quick power-down after 3s idle
module pdc_power_down_controller #(
    parameter int US_PER_MS = pdc_pkg::US_PER_MS
) (
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    input  wire pdc_pkg::pdc_bus_req_t busReq,
    output logic [7:0]                 busRdata,
    input  wire logic                  processorIrqInput,
    input  wire logic                  standbyTerminal,
    input  wire logic                  activityEvent,
    input  wire pdc_pkg::pdc_cycle_t   hostCycle,
    input  wire logic                  swResetMaskIn,
    output logic                       clockStopRequest,
    output logic                       clockSlowRequest,
    output logic                       systemMgmtIrq,
    output logic                       powerDownLed,
    output logic                       processorMgmtModeAlt,
    output logic                       swResetMask,
    output logic                       specialMatch
);
    logic [7:0]         timersReg_q;
    logic [7:0]         modeReg_q;
    logic [7:0]         ctlReg_q;
    logic [7:0]         indReg_q;
    logic [7:0]         matchReg_q;
    logic [1:0]         quickReg_q;
    logic [7:0]         rdata_q;
    logic [3:0]         usDiv_q;
    logic [9:0]         msDiv_q;
    logic               usTick;
    logic               msTick;
    pdc_pkg::pdc_susp_t suspState_q;
    logic [24:0]        suspCnt_q;
    logic [24:0]        suspLimit;
    logic               suspEn;
    logic               suspTc;
    logic               suspTcFlag_q;
    logic               irqAct;
    logic               irqPrev_q;
    logic               irqRise;
    logic               wakeRun_q;
    logic [15:0]        wakeCnt_q;
    logic               wakeSeen_q;
    logic               wakeTc;
    logic               stopAuto_q;
    logic               pdActive_q;
    logic               anyMode;
    logic [11:0]        quickCnt_q;
    logic               quickTc;
    logic [8:0]         ledCnt_q;
    logic               ledPhase_q;
    logic               mgmt_q;
    logic               stop_q;
    logic               slow_q;
    logic               led_q;
    logic               style_q;
    logic               rstMask_q;
    logic               match_q;
    logic               wrCtl;
    logic [7:0]         status;

    assign busRdata             = rdata_q;
    assign clockStopRequest     = stop_q;
    assign clockSlowRequest     = slow_q;
    assign systemMgmtIrq        = mgmt_q;
    assign powerDownLed         = led_q;
    assign processorMgmtModeAlt = style_q;
    assign swResetMask          = rstMask_q;
    assign specialMatch         = match_q;

    assign wrCtl   = busReq.wr && busReq.addr == pdc_pkg::ADDR_CTL;
    assign anyMode = modeReg_q[pdc_pkg::MODE_HW] | modeReg_q[pdc_pkg::MODE_SW];
    // bits 0, 1 and 4 of the mode register are stored only; software keeps them
    assign status  = {3'h0, mgmt_q, slow_q, stop_q, pdActive_q, suspTcFlag_q};

    // register writes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            timersReg_q <= pdc_pkg::REG_RESET;
            modeReg_q   <= pdc_pkg::REG_RESET;
            ctlReg_q    <= pdc_pkg::REG_RESET;
            indReg_q    <= pdc_pkg::REG_RESET;
            matchReg_q  <= pdc_pkg::REG_RESET;
            quickReg_q  <= 2'h0;
        end else if (busReq.wr) begin
            case (busReq.addr)
                pdc_pkg::ADDR_TIMERS: timersReg_q <= busReq.wdata;
                pdc_pkg::ADDR_MODE:   modeReg_q   <= busReq.wdata;
                pdc_pkg::ADDR_CTL:    ctlReg_q    <= busReq.wdata;
                pdc_pkg::ADDR_IND:    indReg_q    <= busReq.wdata;
                pdc_pkg::ADDR_MATCH:  matchReg_q  <= busReq.wdata;
                pdc_pkg::ADDR_QUICK:  quickReg_q  <= busReq.wdata[1:0];
                default: ;
            endcase
        end
    end

    // read data stands one cycle, zero otherwise and for unmapped addresses
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else if (busReq.rd) begin
            case (busReq.addr)
                pdc_pkg::ADDR_TIMERS: rdata_q <= timersReg_q;
                pdc_pkg::ADDR_MODE:   rdata_q <= modeReg_q;
                pdc_pkg::ADDR_CTL:    rdata_q <= ctlReg_q;
                pdc_pkg::ADDR_IND:    rdata_q <= indReg_q;
                pdc_pkg::ADDR_MATCH:  rdata_q <= matchReg_q;
                pdc_pkg::ADDR_STATUS: rdata_q <= status;
                pdc_pkg::ADDR_QUICK:  rdata_q <= {6'h00, quickReg_q};
                default:              rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // shared timebase: us tick, then ms tick chained from it
    assign usTick = usDiv_q == 4'(pdc_pkg::US_CYCLES - 1);
    assign msTick = usTick && msDiv_q == 10'(US_PER_MS - 1);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            usDiv_q <= 4'h0;
            msDiv_q <= 10'h000;
        end else begin
            usDiv_q <= usTick ? 4'h0 : usDiv_q + 4'h1;
            if (msTick) begin
                msDiv_q <= 10'h000;
            end else if (usTick) begin
                msDiv_q <= msDiv_q + 10'h001;
            end
        end
    end

    // suspend timer
    assign suspEn    = !ctlReg_q[pdc_pkg::CTL_SUSP_DIS];
    assign suspLimit = pdc_pkg::pdc_suspend_ms(timersReg_q[7:4]);
    // >= so a period shortened mid-count still expires
    assign suspTc    = suspState_q == pdc_pkg::SUSP_COUNT && msTick && suspCnt_q >= suspLimit - 25'd1;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            suspState_q <= pdc_pkg::SUSP_OFF;
            suspCnt_q   <= 25'd0;
        end else if (!suspEn) begin
            suspState_q <= pdc_pkg::SUSP_OFF;
            suspCnt_q   <= 25'd0;
        end else begin
            case (suspState_q)
                pdc_pkg::SUSP_OFF: begin
                    suspState_q <= pdc_pkg::SUSP_WAIT; // re-enable restarts
                end
                pdc_pkg::SUSP_WAIT: begin
                    if (standbyTerminal) begin
                        suspState_q <= pdc_pkg::SUSP_COUNT;
                    end
                    suspCnt_q <= 25'd0;
                end
                pdc_pkg::SUSP_COUNT: begin
                    if (suspTc) begin
                        suspState_q <= pdc_pkg::SUSP_DONE;
                    end else if (msTick) begin
                        suspCnt_q <= suspCnt_q + 25'd1;
                    end
                end
                pdc_pkg::SUSP_DONE: begin
                    suspState_q <= pdc_pkg::SUSP_DONE;
                end
                default: suspState_q <= pdc_pkg::SUSP_OFF;
            endcase
        end
    end

    // expiry flag; setting wins over the disable clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            suspTcFlag_q <= 1'b0;
        end else if (suspTc) begin
            suspTcFlag_q <= 1'b1;
        end else if (!suspEn) begin
            suspTcFlag_q <= 1'b0;
        end
    end

    // gated processor interrupt, rising edge
    assign irqAct  = processorIrqInput & modeReg_q[pdc_pkg::MODE_IRQ_EN];
    assign irqRise = irqAct & ~irqPrev_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irqPrev_q <= 1'b0;
        end else begin
            irqPrev_q <= irqAct;
        end
    end

    // wake timer, started by an interrupt while powered down
    assign wakeTc = wakeRun_q && usTick && wakeCnt_q >= pdc_pkg::pdc_wake_us(timersReg_q[3:0]) - 16'd1;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wakeRun_q  <= 1'b0;
            wakeCnt_q  <= 16'd0;
            wakeSeen_q <= 1'b0;
        end else if (irqRise && pdActive_q && !modeReg_q[pdc_pkg::MODE_WAKE_DIS]) begin
            wakeRun_q  <= 1'b1;
            wakeCnt_q  <= 16'd0;
            wakeSeen_q <= 1'b0;
        end else if (wakeTc || modeReg_q[pdc_pkg::MODE_WAKE_DIS]) begin
            wakeRun_q <= 1'b0;
        end else if (wakeRun_q) begin
            if (usTick) begin
                wakeCnt_q <= wakeCnt_q + 16'd1;
            end
            if (activityEvent) begin
                wakeSeen_q <= 1'b1;
            end
        end
    end

    // automatic clock-stop: interrupt wins over a same-cycle re-stop
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stopAuto_q <= 1'b0;
        end else if (irqRise || !anyMode) begin
            stopAuto_q <= 1'b0;
        end else if (suspTc && modeReg_q[pdc_pkg::MODE_HW]) begin
            stopAuto_q <= 1'b1;
        end else if (wakeTc && !wakeSeen_q && !activityEvent) begin
            stopAuto_q <= 1'b1;
        end
    end

    // power-down state: entered by expiry or quick idle, left on activity
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pdActive_q <= 1'b0;
        end else if (!anyMode) begin
            pdActive_q <= 1'b0;
        end else if (suspTc || quickTc) begin
            pdActive_q <= 1'b1;
        end else if (activityEvent) begin
            pdActive_q <= 1'b0;
        end
    end

    // quick power-down idle counter in ms
    assign quickTc = msTick && quickCnt_q == 12'(pdc_pkg::QUICK_PD_MS - 1);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            quickCnt_q <= 12'h000;
        end else if (!(&quickReg_q) || activityEvent || pdActive_q) begin
            quickCnt_q <= 12'h000;
        end else if (msTick && !quickTc) begin
            quickCnt_q <= quickCnt_q + 12'h001;
        end
    end

    // management interrupt: setting wins over the clear write
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mgmt_q <= 1'b0;
        end else if ((wrCtl && busReq.wdata[pdc_pkg::CTL_MGMT_SET]) ||
                     (suspTc && modeReg_q[pdc_pkg::MODE_SW])) begin
            mgmt_q <= 1'b1;
        end else if (wrCtl && busReq.wdata[pdc_pkg::CTL_MGMT_CLR]) begin
            mgmt_q <= 1'b0;
        end
    end

    // clock-stop and clock-slow outputs; force-on outranks force-off
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stop_q <= 1'b0;
        end else if (ctlReg_q[pdc_pkg::CTL_STOP_ON]) begin
            stop_q <= 1'b1;
        end else if (ctlReg_q[pdc_pkg::CTL_STOP_OFF]) begin
            stop_q <= 1'b0;
        end else begin
            stop_q <= stopAuto_q;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            slow_q <= 1'b0;
        end else if (ctlReg_q[pdc_pkg::CTL_SLOW_ON]) begin
            slow_q <= 1'b1;
        end else if (ctlReg_q[pdc_pkg::CTL_SLOW_OFF]) begin
            slow_q <= 1'b0;
        end else if (modeReg_q[pdc_pkg::MODE_SLOW_IRQ] && irqAct) begin
            slow_q <= 1'b0;
        end else begin
            slow_q <= modeReg_q[pdc_pkg::MODE_HW] && pdActive_q;
        end
    end

    // indicator led, half period in ms ticks
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ledCnt_q   <= 9'h000;
            ledPhase_q <= 1'b0;
        end else if (!pdActive_q) begin
            ledCnt_q   <= 9'h000;
            ledPhase_q <= 1'b0;
        end else if (msTick) begin
            if (ledCnt_q == 9'(pdc_pkg::LED_HALF_MS - 1)) begin
                ledCnt_q   <= 9'h000;
                ledPhase_q <= !ledPhase_q;
            end else begin
                ledCnt_q <= ledCnt_q + 9'h001;
            end
        end
    end

    // misc outputs: led, style, reset mask, address match
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            led_q     <= 1'b0;
            style_q   <= 1'b0;
            rstMask_q <= 1'b0;
            match_q   <= 1'b0;
        end else begin
            led_q <= (indReg_q[pdc_pkg::IND_LED_EN] && pdActive_q && ledPhase_q)
                     ^ indReg_q[pdc_pkg::IND_LED_LOW];
            style_q   <= indReg_q[pdc_pkg::IND_STYLE];
            rstMask_q <= swResetMaskIn && !ctlReg_q[pdc_pkg::CTL_RSTMASK_OFF];
            match_q   <= hostCycle.valid && (hostCycle.mem
                         ? {hostCycle.addr[31], hostCycle.addr[26:20]} == matchReg_q
                         : hostCycle.addr[7:0] == matchReg_q);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_tc_hw;
        suspTc && modeReg_q[pdc_pkg::MODE_HW] && !irqRise;
    endsequence
    sequence s_mgmt_write;
        wrCtl && busReq.wdata[pdc_pkg::CTL_MGMT_SET];
    endsequence

    a_mgmt_raise: assert property (s_mgmt_write ##1 !(wrCtl && busReq.wdata[pdc_pkg::CTL_MGMT_CLR])
        |-> systemMgmtIrq ##1 systemMgmtIrq)
        else $error("management irq not raised by control write");
    a_mgmt_sole_clear: assert property (systemMgmtIrq && !(wrCtl && busReq.wdata[pdc_pkg::CTL_MGMT_CLR])
        |=> systemMgmtIrq)
        else $error("management irq dropped without clear write");
    a_stop_forced_on: assert property (ctlReg_q[pdc_pkg::CTL_STOP_ON] |=> clockStopRequest)
        else $error("clock-stop not forced on");
    a_stop_forced_off: assert property (ctlReg_q[5:4] == 2'h1 |=> !clockStopRequest)
        else $error("clock-stop not forced off");
    a_slow_forced_on: assert property (ctlReg_q[pdc_pkg::CTL_SLOW_ON] |=> clockSlowRequest)
        else $error("clock-slow not forced on");
    a_slow_forced_off: assert property (ctlReg_q[3:2] == 2'h1 |=> !clockSlowRequest)
        else $error("clock-slow not forced off");
    a_susp_disabled: assert property (!suspEn |=> suspState_q == pdc_pkg::SUSP_OFF)
        else $error("suspend timer runs while disabled");
    a_susp_waits: assert property (suspState_q == pdc_pkg::SUSP_WAIT && !standbyTerminal
        |=> suspState_q != pdc_pkg::SUSP_COUNT)
        else $error("suspend counting before stand-by expiry");
    a_hw_stop_tc: assert property (s_tc_hw |=> stopAuto_q)
        else $error("no clock-stop at suspend expiry");
    a_sw_mgmt_tc: assert property (suspTc && modeReg_q[pdc_pkg::MODE_SW] |=> systemMgmtIrq)
        else $error("no management irq at suspend expiry");
    a_irq_unstops: assert property (irqRise |=> !stopAuto_q)
        else $error("interrupt did not release clock-stop");
    a_flag_tc: assert property (suspTc |=> suspTcFlag_q ##1 (suspTcFlag_q || !$past(suspEn)))
        else $error("suspend expiry flag not set");
    a_rdata_window: assert property (!$past(busReq.rd) |-> busRdata == 8'h00)
        else $error("read data outside its cycle");
endmodule : pdc_power_down_controller
`default_nettype wire

// [shared/pdc_pkg.sv]
// constants, types and period tables for the power-down controller
`default_nettype none
package pdc_pkg;
    localparam logic [7:0] ADDR_TIMERS = 8'h50;
    localparam logic [7:0] ADDR_MODE   = 8'h51;
    localparam logic [7:0] ADDR_CTL    = 8'h52;
    localparam logic [7:0] ADDR_IND    = 8'h53;
    localparam logic [7:0] ADDR_MATCH  = 8'h54;
    localparam logic [7:0] ADDR_STATUS = 8'h60;
    localparam logic [7:0] ADDR_QUICK  = 8'h61;
    localparam logic [7:0] REG_RESET   = 8'h00;

    localparam int MODE_HW          = 7;
    localparam int MODE_SW          = 6;
    localparam int MODE_IRQ_EN      = 5;
    localparam int MODE_SLOW_IRQ    = 3;
    localparam int MODE_WAKE_DIS    = 2;
    localparam int CTL_MGMT_SET     = 7;
    localparam int CTL_MGMT_CLR     = 6;
    localparam int CTL_STOP_ON      = 5;
    localparam int CTL_STOP_OFF     = 4;
    localparam int CTL_SLOW_ON      = 3;
    localparam int CTL_SLOW_OFF     = 2;
    localparam int CTL_SUSP_DIS     = 1;
    localparam int CTL_RSTMASK_OFF  = 0;
    localparam int IND_LED_EN       = 3;
    localparam int IND_LED_LOW      = 2;
    localparam int IND_STYLE        = 1;
    localparam int QCK_EN           = 0;
    localparam int QCK_PIN          = 1;

    localparam int CLK_PERIOD_NS    = 100;
    localparam int TIMEBASE_NS      = 1000;
    localparam int US_CYCLES        = (TIMEBASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int US_PER_MS        = 1000;
    localparam int QUICK_PD_S       = 3;
    localparam int QUICK_PD_MS      = QUICK_PD_S * 1000;
    localparam int LED_HALF_MS      = 500;

    typedef enum logic [1:0] {
        SUSP_OFF   = 2'h0,
        SUSP_WAIT  = 2'h1,
        SUSP_COUNT = 2'h3,
        SUSP_DONE  = 2'h2
    } pdc_susp_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pdc_bus_req_t;

    typedef struct packed {
        logic [31:0] addr;
        logic        mem;
        logic        valid;
    } pdc_cycle_t;

    // suspend period in ms ticks
    function automatic logic [24:0] pdc_suspend_ms(input logic [3:0] code);
        case (code)
            4'h0:    pdc_suspend_ms = 25'd228000;
            4'h1:    pdc_suspend_ms = 25'd450000;
            4'h2:    pdc_suspend_ms = 25'd900000;
            4'h3:    pdc_suspend_ms = 25'd1800000;
            4'h4:    pdc_suspend_ms = 25'd3600000;
            4'h5:    pdc_suspend_ms = 25'd7200000;
            4'h6:    pdc_suspend_ms = 25'd14400000;
            4'h7:    pdc_suspend_ms = 25'd28800000;
            4'h8:    pdc_suspend_ms = 25'd1000;
            4'h9:    pdc_suspend_ms = 25'd1800;
            4'hA:    pdc_suspend_ms = 25'd3500;
            4'hB:    pdc_suspend_ms = 25'd7000;
            4'hC:    pdc_suspend_ms = 25'd14000;
            4'hD:    pdc_suspend_ms = 25'd28000;
            4'hE:    pdc_suspend_ms = 25'd56000;
            default: pdc_suspend_ms = 25'd120000;
        endcase
    endfunction : pdc_suspend_ms

    // wake period in us ticks; reserved codes fall back to the shortest
    function automatic logic [15:0] pdc_wake_us(input logic [3:0] code);
        case (code)
            4'h6:    pdc_wake_us = 16'd107;
            4'h7:    pdc_wake_us = 16'd215;
            4'h8:    pdc_wake_us = 16'd430;
            4'h9:    pdc_wake_us = 16'd860;
            4'hA:    pdc_wake_us = 16'd1700;
            4'hB:    pdc_wake_us = 16'd3400;
            4'hC:    pdc_wake_us = 16'd7000;
            4'hD:    pdc_wake_us = 16'd14000;
            4'hE:    pdc_wake_us = 16'd28000;
            4'hF:    pdc_wake_us = 16'd55000;
            default: pdc_wake_us = 16'd54;
        endcase
    endfunction : pdc_wake_us
endpackage : pdc_pkg
`default_nettype wire

// [bench/pdc_cpu_model.sv]
// host processor model: raises its interrupt on request, counts mgmt irqs
`timescale 1ns/1ns
`default_nettype none
module pdc_cpu_model (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       fire,
    input  wire logic       systemMgmtIrq,
    output logic            processorIrqInput,
    output logic [7:0]      smiCount
);
    logic [7:0] holdQ;
    logic       smiQ;
    // irq held 16 cycles so registered reactions are visible while it stands
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            holdQ <= 8'h00;
        end else if (fire) begin
            holdQ <= 8'h10;
        end else if (holdQ != 8'h00) begin
            holdQ <= holdQ - 8'h01;
        end
    end
    assign processorIrqInput = (holdQ != 8'h00);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            smiQ     <= 1'b0;
            smiCount <= 8'h00;
        end else begin
            smiQ <= systemMgmtIrq;
            if (systemMgmtIrq && !smiQ) begin
                smiCount <= smiCount + 8'h01;
            end
        end
    end
endmodule : pdc_cpu_model
`default_nettype wire

// [bench/pdc_power_down_controller_tb.sv]
// self-checking bench for the power-down controller
`timescale 1ns/1ns
`default_nettype none
module pdc_power_down_controller_tb;
    localparam int MSCYC = 20;
    localparam int SUSP  = MSCYC * 1000;
    logic                  clk_sys = 1'b0;
    logic                  arst_n = 1'b0;
    pdc_pkg::pdc_bus_req_t busReq = '0;
    pdc_pkg::pdc_cycle_t   hostCycle = '0;
    logic                  stby = 1'b0;
    logic                  act = 1'b0;
    logic                  rmIn = 1'b0;
    logic                  fire = 1'b0;
    logic [7:0]            busRdata, smiCount, v, rv, base;
    logic                  stop, slow, system_mgmt_irq, led, alt, rmask, match, cpuIrq;
    logic [31:0]           hostAddr;
    int                    n_mismatch = 0;
    int                    samples_checked = 0;
    logic [7:0]            addrs [6] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h7F};
    always #50 clk_sys = ~clk_sys;
    pdc_power_down_controller #(.US_PER_MS(2)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .busReq(busReq),
        .busRdata(busRdata), .processorIrqInput(cpuIrq), .standbyTerminal(stby), .activityEvent(act),
        .hostCycle(hostCycle), .swResetMaskIn(rmIn), .clockStopRequest(stop), .clockSlowRequest(slow),
        .systemMgmtIrq(system_mgmt_irq), .powerDownLed(led), .processorMgmtModeAlt(alt), .swResetMask(rmask),
        .specialMatch(match));
    pdc_cpu_model cpu (.clk_sys(clk_sys), .arst_n(arst_n), .fire(fire), .systemMgmtIrq(system_mgmt_irq),
        .processorIrqInput(cpuIrq), .smiCount(smiCount));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        busReq.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        busReq.rd <= 1'b0;
        #1;
        d = busRdata;
    endtask : rd
    task automatic waitHi(ref logic s, input int lim, input string what);
        for (int i = 0; i < lim && s !== 1'b1; i++) tick(1);
        chk(s, 1'b1, what);
    endtask : waitHi
    function automatic logic expMatch(input logic [7:0] m, input logic [31:0] a, input logic mem);
        return mem ? ({a[31], a[26:20]} == m) : (a[7:0] == m);
    endfunction : expMatch
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_mismatch++;
        conclude();
    end
    initial begin
        v = $urandom(32'hAA54);
        tick(16);
        arst_n <= 1'b1;
        foreach (addrs[i]) begin
            rd(addrs[i], rv);
            chk(rv, 8'h00, "reset value");
        end
        v = $urandom;
        wr(8'h53, v & 8'h0F);
        wr(8'h54, v);
        wr(8'h60, 8'hFF);
        rd(8'h54, rv);
        chk(rv, v, "match readback");
        rd(8'h60, rv);
        chk(rv, 8'h00, "status read-only");
        wr(8'h61, 8'h01);
        rd(8'h61, rv);
        chk(rv, 8'h01, "quick enable readback");
        chk(alt, v[1], "style select");
        $display("test registers done");
        wr(8'h52, 8'h80);
        tick(1);
        chk(system_mgmt_irq, 1'b1, "mgmt set");
        wr(8'h52, 8'h00);
        tick(5);
        chk(system_mgmt_irq, 1'b1, "mgmt holds");
        wr(8'h52, 8'h40);
        tick(1);
        chk(system_mgmt_irq, 1'b0, "mgmt clear");
        wr(8'h52, 8'h00);
        for (int k = 3; k <= 5; k += 2) begin
            wr(8'h52, 8'h01 << k);
            tick(1);
            chk(k == 5 ? stop : slow, 1'b1, "force on");
            wr(8'h52, 8'h00);
            tick(1);
            chk(k == 5 ? stop : slow, 1'b0, "force released");
        end
        rmIn <= 1'b1;
        wr(8'h52, 8'h01);
        tick(2);
        chk(rmask, 1'b0, "reset mask off");
        wr(8'h52, 8'h00);
        tick(2);
        chk(rmask, 1'b1, "reset mask back");
        $display("test controls done");
        for (int j = 0; j < 8; j++) begin
            hostAddr = $urandom;
            if (j < 4 && j[0]) hostAddr[31:20] = {v[7], 4'h0, v[6:0]};
            if (j < 4 && !j[0]) hostAddr[7:0] = v;
            hostCycle <= '{addr: hostAddr, mem: j[0], valid: 1'b1};
            tick(1);
            chk(match, expMatch(v, hostAddr, j[0]), "special match");
        end
        hostCycle <= '0;
        $display("test match done");
        wr(8'h50, 8'h85);
        wr(8'h51, 8'hA8);
        wr(8'h53, 8'h0C);
        tick(100);
        chk(stop, 1'b0, "no count before stand-by");
        chk(led, 1'b1, "led idle active-low");
        stby <= 1'b1;
        tick(SUSP - 100);
        chk(stop, 1'b0, "suspend not early");
        waitHi(stop, 300, "stop at expiry");
        tick(3);
        rd(8'h60, rv);
        chk(rv, 8'h0F, "status powered down");
        wr(8'h52, 8'h14);
        tick(1);
        chk({stop, slow}, 2'b00, "forced off");
        wr(8'h52, 8'h00);
        tick(2);
        chk({stop, slow}, 2'b11, "auto again");
        fire <= 1'b1;
        tick(1);
        fire <= 1'b0;
        tick(3);
        chk({stop, slow}, 2'b00, "irq wakes");
        tick(500);
        chk(stop, 1'b0, "wake period");
        waitHi(stop, 100, "re-stop");
        fire <= 1'b1;
        tick(1);
        fire <= 1'b0;
        tick(20);
        act <= 1'b1;
        tick(1);
        act <= 1'b0;
        tick(600);
        chk(stop, 1'b0, "activity cancels");
        $display("test hardware mode done");
        wr(8'h52, 8'h02);
        rd(8'h60, rv);
        chk(rv[0], 1'b0, "flag cleared");
        wr(8'h51, 8'h61);
        base = smiCount;
        wr(8'h52, 8'h00);
        tick(SUSP - 100);
        chk(system_mgmt_irq, 1'b0, "sw not early");
        waitHi(system_mgmt_irq, 300, "sw expiry irq");
        chk(stop, 1'b0, "sw no stop");
        wr(8'h52, 8'h40);
        wr(8'h52, 8'h02);
        wr(8'h52, 8'h00);
        waitHi(system_mgmt_irq, SUSP + 300, "second expiry");
        tick(1);
        chk(smiCount, base + 8'h02, "two irqs");
        $display("test software mode done");
        conclude();
    end
endmodule : pdc_power_down_controller_tb
`default_nettype wire
